// ### hw/sdtp_pkg.sv
// Purpose: Constants for the dynamic-memory timing parameter bank.
// Assumes: 32-bit APB register bus, one aligned word per register.
// Notes: Offsets are local choices, packed one aligned word apart.
package sdtp_pkg;
    // ****************************************************************
    // Register offsets
    // ****************************************************************
    localparam logic [7:0] SDTP_OFS_PRECHARGE = 8'h00;
    localparam logic [7:0] SDTP_OFS_ACT_TO_PRE = 8'h04;
    localparam logic [7:0] SDTP_OFS_SREF_EXIT = 8'h08;
    localparam logic [7:0] SDTP_OFS_WRITE_REC = 8'h0c;
    localparam logic [7:0] SDTP_OFS_ACT_TO_ACT = 8'h10;
    localparam logic [7:0] SDTP_OFS_AUTO_REF = 8'h14;
    localparam logic [7:0] SDTP_OFS_XSR_TO_ACT = 8'h18;
    // ****************************************************************
    // Field widths and reset values
    // ****************************************************************
    localparam int SDTP_W_RP = 4;
    localparam int SDTP_W_RAS = 4;
    localparam int SDTP_W_SREX = 7;
    localparam int SDTP_W_WR = 4;
    localparam int SDTP_W_RC = 5;
    localparam int SDTP_W_RFC = 5;
    localparam int SDTP_W_XSR = 8;
    localparam logic [3:0] SDTP_RST_RP = 4'hf;
    localparam logic [3:0] SDTP_RST_RAS = 4'hf;
    localparam logic [6:0] SDTP_RST_SREX = 7'h7f;
    localparam logic [3:0] SDTP_RST_WR = 4'hf;
    localparam logic [4:0] SDTP_RST_RC = 5'h1f;
    localparam logic [4:0] SDTP_RST_RFC = 5'h1f;
    localparam logic [7:0] SDTP_RST_XSR = 8'hff;
    // Number of wait states inserted on every register access.
    localparam int SDTP_WAIT_STATES = 1;
    // Number of chip selects sharing one set of values.
    localparam int SDTP_NUM_CS = 4;
    // Interval selectors for the sequencer-facing timer.
    typedef enum logic [2:0] {
        SDTP_T_RP, SDTP_T_RAS, SDTP_T_SREX, SDTP_T_WR, SDTP_T_RC, SDTP_T_RFC, SDTP_T_XSR
    } sdtp_interval_e;
endpackage

// ### hw/sdtp_timing_regs.sv
// Purpose: APB register bank of SDRAM timing values plus an interval timer.
// Assumes: Single clock, synchronous active-high reset used as power-on reset.
// Notes: Each field code n means n+1 cycles of the controller clock.
`timescale 1ns/1ps
module sdtp_timing_regs
    import sdtp_pkg::*;
(
    input wire logic clk_in,
    input wire logic sys_rst_in,
    input wire logic psel_in,
    input wire logic penable_in,
    input wire logic pwrite_in,
    input wire logic [7:0] paddr_in,
    input wire logic [31:0] pwdata_in,
    output logic [31:0] prdata_out,
    output logic pready_out,
    output logic pslverr_out,
    input wire logic timer_start_in,
    input wire logic [2:0] timer_sel_in,
    output logic timer_busy_out,
    output logic timer_done_out,
    output logic [3:0] precharge_out,
    output logic [3:0] act_to_pre_out,
    output logic [6:0] sref_exit_out,
    output logic [3:0] write_rec_out,
    output logic [4:0] act_to_act_out,
    output logic [4:0] auto_ref_out,
    output logic [7:0] xsr_to_act_out
);
    // ****************************************************************
    // Register bank
    // ****************************************************************
    logic [3:0] precharge_period, next_precharge_period;
    logic [3:0] activate_to_precharge_period, next_activate_to_precharge_period;
    logic [6:0] self_refresh_exit_time, next_self_refresh_exit_time;
    logic [3:0] write_recovery_time, next_write_recovery_time;
    logic [4:0] activate_to_activate_period, next_activate_to_activate_period;
    logic [4:0] auto_refresh_period, next_auto_refresh_period;
    logic [7:0] exit_self_refresh_to_activate, next_exit_self_refresh_to_activate;
    logic wait_done, next_wait_done;
    logic [31:0] rdata, next_rdata;
    logic addr_hit;
    logic access_end;

    // The access phase stalls one cycle, so pready rises in the second access cycle.
    assign pready_out = psel_in && penable_in && wait_done;
    assign access_end = pready_out;
    assign pslverr_out = access_end && !addr_hit;
    assign prdata_out = rdata;

    // Decode, read mux, wait state and write path.
    always_comb begin
        next_precharge_period = precharge_period;
        next_activate_to_precharge_period = activate_to_precharge_period;
        next_self_refresh_exit_time = self_refresh_exit_time;
        next_write_recovery_time = write_recovery_time;
        next_activate_to_activate_period = activate_to_activate_period;
        next_auto_refresh_period = auto_refresh_period;
        next_exit_self_refresh_to_activate = exit_self_refresh_to_activate;
        next_wait_done = psel_in && penable_in && !wait_done;
        next_rdata = rdata;
        addr_hit = 1'b1;
        // Reserved bits read as zero, which is one legal undefined value.
        unique case (paddr_in)
            SDTP_OFS_PRECHARGE: next_rdata = {28'h0000000, precharge_period};
            SDTP_OFS_ACT_TO_PRE: next_rdata = {28'h0000000, activate_to_precharge_period};
            SDTP_OFS_SREF_EXIT: next_rdata = {25'h0000000, self_refresh_exit_time};
            SDTP_OFS_WRITE_REC: next_rdata = {28'h0000000, write_recovery_time};
            SDTP_OFS_ACT_TO_ACT: next_rdata = {27'h0000000, activate_to_activate_period};
            SDTP_OFS_AUTO_REF: next_rdata = {27'h0000000, auto_refresh_period};
            SDTP_OFS_XSR_TO_ACT: next_rdata = {24'h000000, exit_self_refresh_to_activate};
            default: begin
                next_rdata = 32'h00000000;
                addr_hit = 1'b0;
            end
        endcase
        if (!(psel_in && !pwrite_in && penable_in && !wait_done)) begin
            next_rdata = rdata;
        end
        // Writes land only at the completing edge; reserved write bits are dropped.
        if (access_end && pwrite_in) begin
            unique case (paddr_in)
                SDTP_OFS_PRECHARGE: next_precharge_period = pwdata_in[3:0];
                SDTP_OFS_ACT_TO_PRE: next_activate_to_precharge_period = pwdata_in[3:0];
                SDTP_OFS_SREF_EXIT: next_self_refresh_exit_time = pwdata_in[6:0];
                SDTP_OFS_WRITE_REC: next_write_recovery_time = pwdata_in[3:0];
                SDTP_OFS_ACT_TO_ACT: next_activate_to_activate_period = pwdata_in[4:0];
                SDTP_OFS_AUTO_REF: next_auto_refresh_period = pwdata_in[4:0];
                SDTP_OFS_XSR_TO_ACT: next_exit_self_refresh_to_activate = pwdata_in[7:0];
                default: ;
            endcase
        end
    end

    // Reset loads the maxima; 7'h7f gives the 128-cycle self-refresh exit.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            precharge_period <= SDTP_RST_RP;
            activate_to_precharge_period <= SDTP_RST_RAS;
            self_refresh_exit_time <= SDTP_RST_SREX;
            write_recovery_time <= SDTP_RST_WR;
            activate_to_activate_period <= SDTP_RST_RC;
            auto_refresh_period <= SDTP_RST_RFC;
            exit_self_refresh_to_activate <= SDTP_RST_XSR;
            wait_done <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            precharge_period <= next_precharge_period;
            activate_to_precharge_period <= next_activate_to_precharge_period;
            self_refresh_exit_time <= next_self_refresh_exit_time;
            write_recovery_time <= next_write_recovery_time;
            activate_to_activate_period <= next_activate_to_activate_period;
            auto_refresh_period <= next_auto_refresh_period;
            exit_self_refresh_to_activate <= next_exit_self_refresh_to_activate;
            wait_done <= next_wait_done;
            rdata <= next_rdata;
        end
    end

    // One shared set feeds every chip select, so no per-select copy exists.
    assign precharge_out = precharge_period;
    assign act_to_pre_out = activate_to_precharge_period;
    assign sref_exit_out = self_refresh_exit_time;
    assign write_rec_out = write_recovery_time;
    assign act_to_act_out = activate_to_activate_period;
    assign auto_ref_out = auto_refresh_period;
    assign xsr_to_act_out = exit_self_refresh_to_activate;

    // ****************************************************************
    // Interval timer for the command sequencer
    // ****************************************************************
    logic [7:0] tcount, next_tcount;
    logic tbusy, next_tbusy;
    logic tdone, next_tdone;
    logic [7:0] tload;

    // The code is loaded as is: n counts down to zero in n+1 cycles.
    always_comb begin
        unique case (timer_sel_in)
            SDTP_T_RP: tload = {4'h0, precharge_period};
            SDTP_T_RAS: tload = {4'h0, activate_to_precharge_period};
            SDTP_T_SREX: tload = {1'b0, self_refresh_exit_time};
            SDTP_T_WR: tload = {4'h0, write_recovery_time};
            SDTP_T_RC: tload = {3'h0, activate_to_activate_period};
            SDTP_T_RFC: tload = {3'h0, auto_refresh_period};
            SDTP_T_XSR: tload = exit_self_refresh_to_activate;
            default: tload = 8'hff;
        endcase
    end

    // A start while busy is ignored; the running interval must finish first.
    always_comb begin
        next_tcount = tcount;
        next_tbusy = tbusy;
        next_tdone = 1'b0;
        if (tbusy) begin
            if (tcount == 8'h00) begin
                next_tbusy = 1'b0;
                next_tdone = 1'b1;
            end else begin
                next_tcount = tcount - 8'h01;
            end
        end else if (timer_start_in) begin
            next_tcount = tload;
            next_tbusy = 1'b1;
        end
    end

    // Timer state; reset leaves it idle so no stale interval survives a restart.
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            tcount <= 8'h00;
            tbusy <= 1'b0;
            tdone <= 1'b0;
        end else begin
            tcount <= next_tcount;
            tbusy <= next_tbusy;
            tdone <= next_tdone;
        end
    end

    // Busy and done come straight from flip-flops, so the sequencer sees clean levels.
    assign timer_busy_out = tbusy;
    assign timer_done_out = tdone;

    // ****************************************************************
    // Interval timer and reset-idle assertions
    // ****************************************************************
    // A start is taken only from idle and loads the selected code unchanged.
    AST_TIMER_LOAD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !tbusy && timer_start_in |=> tbusy && tcount == $past(tload))
        else $error("Timer did not load the selected code.");
    AST_TIMER_STEP: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tbusy && tcount != 8'h00 |=> tbusy && tcount == $past(tcount) - 8'h01)
        else $error("Timer did not count down by one.");
    AST_TIMER_END: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tbusy && tcount == 8'h00 |=> !tbusy && tdone)
        else $error("Timer did not end after reaching zero.");
    // Done is a one-cycle strobe; the sequencer may start the next interval in it.
    AST_DONE_PULSE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        tdone |=> !tdone)
        else $error("Done stood for more than one cycle.");
    AST_RESET_IDLE: assert property (@(posedge clk_in)
        sys_rst_in |=> !tbusy && !tdone && !wait_done && prdata_out == 32'h00000000)
        else $error("Timer or bus state not idle after reset.");

    // ****************************************************************
    // Assertions
    // ****************************************************************
    sequence s_access_first;
        psel_in && penable_in && !wait_done;
    endsequence
    sequence s_access_second;
        psel_in && penable_in && wait_done;
    endsequence

    AST_ONE_WAIT: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_access_first |-> !pready_out ##1 (pready_out || !(psel_in && penable_in)))
        else $error("Access did not finish after one wait state.");
    AST_WAIT_ORDER: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        s_access_second |-> $past(psel_in && penable_in))
        else $error("Ready came without a preceding wait cycle.");
    AST_RP_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        access_end && pwrite_in && paddr_in == SDTP_OFS_PRECHARGE |=> precharge_period == $past(pwdata_in[3:0]))
        else $error("Precharge period write lost.");
    AST_RAS_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(access_end && pwrite_in) |=> $stable(activate_to_precharge_period))
        else $error("Activate-to-precharge changed without a write.");
    AST_SREX_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        access_end && pwrite_in && paddr_in == SDTP_OFS_SREF_EXIT |=> self_refresh_exit_time == $past(pwdata_in[6:0]))
        else $error("Self-refresh exit write lost.");
    AST_WR_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        access_end && pwrite_in && paddr_in == SDTP_OFS_WRITE_REC |=> write_recovery_time == $past(pwdata_in[3:0]))
        else $error("Write recovery write lost.");
    AST_RC_RESET: assert property (@(posedge clk_in)
        sys_rst_in |=> activate_to_activate_period == 5'h1f && auto_refresh_period == 5'h1f)
        else $error("Five-bit fields not at maximum after reset.");
    AST_XSR_RESET: assert property (@(posedge clk_in)
        sys_rst_in |=> exit_self_refresh_to_activate == 8'hff && self_refresh_exit_time == 7'h7f)
        else $error("Self-refresh fields not at maximum after reset.");
    AST_RFC_READ: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        (s_access_first and (!pwrite_in && paddr_in == SDTP_OFS_AUTO_REF))
        |=> prdata_out == {27'h0, auto_refresh_period})
        else $error("Auto-refresh readback wrong or reserved bits set.");
    AST_TIMER_LEN: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !tbusy && timer_start_in && timer_sel_in == SDTP_T_RP && precharge_period == 4'h2
        |=> tbusy [*3] ##1 !tbusy && tdone)
        else $error("Timer interval not code plus one cycles.");

    // The remaining fields are checked for a landing write as well.
    AST_RAS_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        access_end && pwrite_in && paddr_in == SDTP_OFS_ACT_TO_PRE
        |=> activate_to_precharge_period == $past(pwdata_in[3:0]))
        else $error("Activate-to-precharge write lost.");
    AST_RC_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        access_end && pwrite_in && paddr_in == SDTP_OFS_ACT_TO_ACT
        |=> activate_to_activate_period == $past(pwdata_in[4:0]))
        else $error("Activate-to-activate write lost.");
    AST_RFC_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        access_end && pwrite_in && paddr_in == SDTP_OFS_AUTO_REF
        |=> auto_refresh_period == $past(pwdata_in[4:0]))
        else $error("Auto-refresh write lost.");
    AST_XSR_WRITE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        access_end && pwrite_in && paddr_in == SDTP_OFS_XSR_TO_ACT
        |=> exit_self_refresh_to_activate == $past(pwdata_in[7:0]))
        else $error("Exit-to-activate write lost.");
    AST_NIBBLE_RESET: assert property (@(posedge clk_in)
        sys_rst_in |=> precharge_period == SDTP_RST_RP && activate_to_precharge_period == SDTP_RST_RAS
            && write_recovery_time == SDTP_RST_WR)
        else $error("Four-bit fields not at maximum after reset.");

    // ****************************************************************
    // Bus framing and read path assertions
    // ****************************************************************
    // Ready is a single-cycle answer; a second high cycle would complete a phantom transfer.
    AST_READY_PULSE: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        pready_out |=> !pready_out)
        else $error("Ready stood for more than one cycle.");
    AST_WAIT_CLEARS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        pready_out |=> !wait_done)
        else $error("Wait state flag not cleared after completion.");
    AST_UNMAPPED_KEEPS: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        access_end && pwrite_in && !addr_hit |=> $stable(precharge_period) && $stable(exit_self_refresh_to_activate))
        else $error("Unmapped write changed a field.");
    // Read data must hold between reads so a slow master still sees its word.
    AST_RDATA_HOLD: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        !(psel_in && penable_in && !wait_done && !pwrite_in) |=> $stable(prdata_out))
        else $error("Read data changed outside a read.");
    AST_RESERVED_ZERO: assert property (@(posedge clk_in) disable iff (sys_rst_in)
        prdata_out[31:8] == 24'h000000)
        else $error("Reserved read bits not zero.");
endmodule

// ### dv/sdtp_seq_model.sv
// Purpose: Command sequencer stand-in that spaces commands by the interval timer.
// Assumes: One clock; go_in is a one-cycle request from the bench.
// Notes: Counts the busy cycles so the bench can judge the interval length.
`timescale 1ns/1ps
module sdtp_seq_model (
    input wire logic clk_in,
    input wire logic go_in,
    input wire logic busy_in,
    output logic start_out,
    output int busy_cycles_out
);
    // ****************************************************************
    // Start request and busy cycle counter
    // ****************************************************************
    initial begin
        start_out = 1'b0;
        busy_cycles_out = 0;
    end
    // A new command is only launched once the previous interval has run out.
    always @(posedge clk_in) begin
        start_out <= go_in & ~busy_in;
        if (busy_in) begin
            busy_cycles_out <= busy_cycles_out + 1;
        end else if (go_in) begin
            busy_cycles_out <= 0;
        end
    end
endmodule

// ### dv/sdtp_timing_regs_tb.sv
// Purpose: Self-checking bench for the timing register bank and its interval timer.
// Assumes: APB master drives after rising edges; slave answer is awaited, never assumed.
// Notes: Expected values come from the package constants and the field encodings.
`timescale 1ns/1ps
module sdtp_timing_regs_tb;
    import sdtp_pkg::*;
    logic clk_in = 1'b0, sys_rst_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, go = 1'b0;
    logic [7:0] paddr_in = 8'h00;
    logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
    logic pready_out, pslverr_out, timer_start_in, timer_busy_out, timer_done_out, err;
    logic [2:0] timer_sel_in = 3'h0;
    logic [3:0] precharge_out, act_to_pre_out, write_rec_out;
    logic [6:0] sref_exit_out;
    logic [4:0] act_to_act_out, auto_ref_out;
    logic [7:0] xsr_to_act_out;
    int mismatches = 0, n_compared = 0, busy_cycles, waits;
    logic [7:0] ofs [7] = '{SDTP_OFS_PRECHARGE, SDTP_OFS_ACT_TO_PRE, SDTP_OFS_SREF_EXIT, SDTP_OFS_WRITE_REC,
        SDTP_OFS_ACT_TO_ACT, SDTP_OFS_AUTO_REF, SDTP_OFS_XSR_TO_ACT};
    int wid [7] = '{SDTP_W_RP, SDTP_W_RAS, SDTP_W_SREX, SDTP_W_WR, SDTP_W_RC, SDTP_W_RFC, SDTP_W_XSR};
    logic [31:0] rst [7] = '{32'(SDTP_RST_RP), 32'(SDTP_RST_RAS), 32'(SDTP_RST_SREX), 32'(SDTP_RST_WR),
        32'(SDTP_RST_RC), 32'(SDTP_RST_RFC), 32'(SDTP_RST_XSR)};
    // ****************************************************************
    // Clock, design and partner
    // ****************************************************************
    always #5 clk_in = ~clk_in;
    // Field outputs picked by index so that loops can walk them.
    function automatic logic [31:0] fld(input int i);
        case (i)
            0: fld = 32'(precharge_out);
            1: fld = 32'(act_to_pre_out);
            2: fld = 32'(sref_exit_out);
            3: fld = 32'(write_rec_out);
            4: fld = 32'(act_to_act_out);
            5: fld = 32'(auto_ref_out);
            default: fld = 32'(xsr_to_act_out);
        endcase
    endfunction
    sdtp_timing_regs i_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .psel_in(psel_in), .penable_in(penable_in),
        .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
        .pready_out(pready_out), .pslverr_out(pslverr_out), .timer_start_in(timer_start_in),
        .timer_sel_in(timer_sel_in), .timer_busy_out(timer_busy_out), .timer_done_out(timer_done_out),
        .precharge_out(precharge_out), .act_to_pre_out(act_to_pre_out), .sref_exit_out(sref_exit_out),
        .write_rec_out(write_rec_out), .act_to_act_out(act_to_act_out), .auto_ref_out(auto_ref_out),
        .xsr_to_act_out(xsr_to_act_out));
    sdtp_seq_model i_seq (.clk_in(clk_in), .go_in(go), .busy_in(timer_busy_out), .start_out(timer_start_in),
        .busy_cycles_out(busy_cycles));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic tally_and_finish();
        if (mismatches == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // One APB transfer; pready is read at each rising edge, before that edge's updates land.
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        waits = 0;
        @(posedge clk_in);
        psel_in <= 1'b1;
        pwrite_in <= w;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge clk_in);
        penable_in <= 1'b1;
        @(posedge clk_in);
        while (pready_out !== 1'b1 && waits < 20) begin
            waits++;
            @(posedge clk_in);
        end
        if (pready_out !== 1'b1) begin
            mismatches++;
            tally_and_finish();
        end
        rd = prdata_out;
        err = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask
    // Run one interval through the partner and judge its length in cycles.
    task automatic run_interval(input logic [2:0] sel, input int exp_cycles);
        int k;
        @(posedge clk_in);
        timer_sel_in <= sel;
        go <= 1'b1;
        @(posedge clk_in);
        go <= 1'b0;
        for (k = 0; k < 400 && timer_done_out !== 1'b1; k++) begin
            @(negedge clk_in);
        end
        if (k == 400) begin
            mismatches++;
            tally_and_finish();
        end
        check("interval", 32'(busy_cycles), 32'(exp_cycles));
    endtask
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_reset_values();
        for (int i = 0; i < 7; i++) begin
            apb(1'b0, ofs[i], 32'h0);
            check("reset read", rd, rst[i]);
            check("wait states", 32'(waits), 32'(SDTP_WAIT_STATES));
            check("mapped err", 32'(err), 32'h0);
            check("reset field", fld(i), rst[i]);
        end
        run_interval(3'h2, 128);
    endtask
    // Writes go in only while the timer is idle, as software is expected to do.
    task automatic t_write_masks();
        logic [31:0] pat [2] = '{32'hffffffff, 32'h5aa5c3f0};
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 7; i++) begin
                apb(1'b1, ofs[i], pat[p]);
                check("write wait", 32'(waits), 32'(SDTP_WAIT_STATES));
                apb(1'b0, ofs[i], 32'h0);
                check("masked read", rd, pat[p] & ((32'h1 << wid[i]) - 32'h1));
                check("shared field", fld(i), pat[p] & ((32'h1 << wid[i]) - 32'h1));
            end
        end
    endtask
    task automatic t_unmapped();
        apb(1'b1, 8'h1c, 32'h0);
        check("unmapped write err", 32'(err), 32'h1);
        apb(1'b0, 8'h1c, 32'h0);
        check("unmapped read err", 32'(err), 32'h1);
        check("unmapped read data", rd, 32'h0);
        check("field kept", fld(6), 32'h000000f0);
    endtask
    // Boundary codes per interval; the exit field copies the exit-to-activate code.
    task automatic t_intervals();
        for (int i = 0; i < 7; i++) begin
            apb(1'b1, ofs[i], 32'h0);
            run_interval(3'(i), 1);
            apb(1'b1, ofs[i], (32'h1 << wid[i]) - 32'h2);
            run_interval(3'(i), (1 << wid[i]) - 1);
            apb(1'b1, ofs[i], (32'h1 << wid[i]) - 32'h1);
            run_interval(3'(i), 1 << wid[i]);
        end
        apb(1'b1, SDTP_OFS_PRECHARGE, 32'h00000002);
        run_interval(3'h0, 3);
        apb(1'b1, SDTP_OFS_XSR_TO_ACT, 32'h00000009);
        apb(1'b1, SDTP_OFS_SREF_EXIT, 32'h00000009);
        run_interval(3'h2, 10);
        run_interval(3'h7, 256);
    endtask
    // A second reset in mid-run must bring every field back to its maximum.
    task automatic t_reset_again();
        @(posedge clk_in);
        sys_rst_in <= 1'b1;
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset_values();
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        repeat (3) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset_values();
        t_write_masks();
        t_unmapped();
        t_intervals();
        t_reset_again();
        tally_and_finish();
    end
endmodule
